// [iobpr_bus_if.sv]
// bus between one peripheral and the host i/o processor
`timescale 1ns/1ps
`default_nettype none
`include "iobpr_params.svh"
interface iobpr_bus_if;
    logic io_sync;
    logic [`IOBPR_LEVELS-1:0] level_request_n;
    logic [`IOBPR_LEVELS-1:0] level_grant;
    logic [`IOBPR_LEVELS-1:0] level_chain_enable;
    logic [`IOBPR_LEVELS-1:0] level_enable_out;
    logic channel_enable_in;
    logic channel_enable_out;
    logic channel_request_n;
    logic one_cycle_request_n;
    logic channel_grant;
    logic add_overflow;
    logic [`IOBPR_ADDR_W-1:0] bus_addr;
    logic bus_addr_oe;
    modport device (
        input io_sync, level_grant, level_chain_enable, channel_enable_in, channel_grant, add_overflow,
        output level_request_n, level_enable_out, channel_enable_out, channel_request_n,
        output one_cycle_request_n, bus_addr, bus_addr_oe
    );
    modport host (
        output io_sync, level_grant, level_chain_enable, channel_enable_in, channel_grant, add_overflow,
        input level_request_n, channel_request_n, one_cycle_request_n, bus_addr, bus_addr_oe
    );
endinterface
`default_nettype wire

// [iobpr_device.sv]
// peripheral end: level requests, channel request, chains and address drive
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "iobpr_params.svh"
module iobpr_device (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // bus
    iobpr_bus_if.device bus,
    // level interrupt user side
    input wire logic [`IOBPR_LEVELS-1:0] level_want_i,
    input wire logic [`IOBPR_ADDR_W-1:0] trap_addr0_i,
    input wire logic [`IOBPR_ADDR_W-1:0] trap_addr1_i,
    input wire logic [`IOBPR_ADDR_W-1:0] trap_addr2_i,
    input wire logic [`IOBPR_ADDR_W-1:0] trap_addr3_i,
    output logic [`IOBPR_LEVELS-1:0] level_pending_o,
    output logic [`IOBPR_LEVELS-1:0] level_served_o,
    // channel user side
    input wire logic channel_want_i,
    input wire iobpr_pkg::iobpr_xfer_t channel_kind_i,
    input wire logic [`IOBPR_ADDR_W-1:0] word_count_addr_i,
    input wire logic [`IOBPR_ADDR_W-1:0] mem_addr_i,
    output logic channel_busy_o,
    output logic channel_served_o,
    // add-to-memory result
    output logic add_error_o
);
    // ---------------------------------------------------------------
    // registered state
    // ---------------------------------------------------------------
    // all state of the peripheral end in one word
    typedef struct packed {
        logic [`IOBPR_LEVELS-1:0] lreq; // posted level requests
        logic [`IOBPR_LEVELS-1:0] lserved;
        iobpr_pkg::iobpr_ch_state_t ch;
        iobpr_pkg::iobpr_xfer_t kind; // transfer class latched at post
        logic cserved;
        logic busy; // channel machine away from idle
        logic add_err;
    } iobpr_dev_state_t;
    iobpr_dev_state_t st_reg;
    iobpr_dev_state_t st_next;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // lowest granted level index, level 0 being the highest
    function automatic logic [1:0] lvl_pick(input logic [`IOBPR_LEVELS-1:0] m);
        if (m[0]) begin
            lvl_pick = 2'h0;
        end else if (m[1]) begin
            lvl_pick = 2'h1;
        end else if (m[2]) begin
            lvl_pick = 2'h2;
        end else begin
            lvl_pick = 2'h3;
        end
    endfunction

    // picks the trap address of one level
    function automatic logic [`IOBPR_ADDR_W-1:0] trap_of(input logic [1:0] lvl,
        input logic [`IOBPR_ADDR_W-1:0] a0, input logic [`IOBPR_ADDR_W-1:0] a1,
        input logic [`IOBPR_ADDR_W-1:0] a2, input logic [`IOBPR_ADDR_W-1:0] a3);
        case (lvl)
            2'h0: trap_of = a0;
            2'h1: trap_of = a1;
            2'h2: trap_of = a2;
            default: trap_of = a3;
        endcase
    endfunction

    // word-count address for multi-cycle work, memory address for one-cycle work
    function automatic logic [`IOBPR_ADDR_W-1:0] chan_addr(input iobpr_pkg::iobpr_xfer_t k,
        input logic [`IOBPR_ADDR_W-1:0] wc, input logic [`IOBPR_ADDR_W-1:0] ma);
        if (k == iobpr_pkg::IOBPR_XFER_MULTI) begin
            chan_addr = wc; // three-cycle class
        end else begin
            chan_addr = ma; // one-cycle class
        end
    endfunction

    // ---------------------------------------------------------------
    // request state
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // served pulses last one cycle
        st_next.lserved = '0;
        st_next.cserved = 1'b0;
        // level requests, one per priority level
        for (int i = 0; i < `IOBPR_LEVELS; i++) begin
            if (st_reg.lreq[i] && bus.level_grant[i]) begin
                st_next.lreq[i] = 1'b0; // withdraw on grant
                st_next.lserved[i] = 1'b1;
            end else if (!st_reg.lreq[i] && level_want_i[i] && bus.io_sync && bus.level_chain_enable[i]) begin
                st_next.lreq[i] = 1'b1; // only at sync, only with enable
            end else if (!bus.level_chain_enable[i] && !bus.level_grant[i]) begin
                st_next.lreq[i] = 1'b0; // upstream holder clears us
            end
        end
        // channel request machine
        case (st_reg.ch)
            // post only while the chain enable reaches us
            iobpr_pkg::IOBPR_CH_IDLE: begin
                if (channel_want_i && bus.channel_enable_in) begin
                    st_next.ch = iobpr_pkg::IOBPR_CH_WAIT;
                    st_next.kind = channel_kind_i;
                end
            end
            // requests stand until the grant is seen
            iobpr_pkg::IOBPR_CH_WAIT: begin
                if (bus.channel_grant) begin
                    st_next.ch = iobpr_pkg::IOBPR_CH_GRANTED;
                end
            end
            // grant seen: wait for it to fall, then report
            iobpr_pkg::IOBPR_CH_GRANTED: begin
                if (!bus.channel_grant) begin
                    st_next.ch = iobpr_pkg::IOBPR_CH_IDLE;
                    st_next.cserved = 1'b1;
                end
            end
            default: st_next.ch = iobpr_pkg::IOBPR_CH_IDLE;
        endcase
        // overflow sticks until a new channel request starts
        if (bus.add_overflow) begin
            st_next.add_err = 1'b1;
        end else if (st_reg.ch == iobpr_pkg::IOBPR_CH_IDLE && st_next.ch == iobpr_pkg::IOBPR_CH_WAIT) begin
            st_next.add_err = 1'b0;
        end
        // busy flag registered so the user output comes from a flop
        st_next.busy = (st_next.ch != iobpr_pkg::IOBPR_CH_IDLE);
        // reset overrides every update above
        if (srst_i) begin
            st_next = '0;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

    // ---------------------------------------------------------------
    // bus drive
    // ---------------------------------------------------------------
    logic ch_req;
    logic ch_gnt;
    logic [`IOBPR_LEVELS-1:0] lgr;
    // request posted and grant seen on the same line
    assign ch_req = (st_reg.ch == iobpr_pkg::IOBPR_CH_WAIT);
    assign ch_gnt = ch_req && bus.channel_grant; // grant answers our standing request
    assign lgr = st_reg.lreq & bus.level_grant;

    // level lines: request low while posted, chain cut below us
    assign bus.level_request_n = ~st_reg.lreq; // active low
    assign bus.level_enable_out = bus.level_chain_enable & ~st_reg.lreq;

    // channel lines: chain cut at once, request pair encodes the class
    assign bus.channel_enable_out = bus.channel_enable_in & ~ch_req;
    assign bus.channel_request_n = ~(ch_req && st_reg.kind != iobpr_pkg::IOBPR_XFER_ONE_OUT);
    assign bus.one_cycle_request_n = ~(ch_req && st_reg.kind != iobpr_pkg::IOBPR_XFER_MULTI);

    // ---------------------------------------------------------------
    // address drive
    // ---------------------------------------------------------------
    // address onto the bus while granted; host never grants two at once
    always_comb begin
        bus.bus_addr = `IOBPR_ADDR_RESET;
        bus.bus_addr_oe = 1'b0;
        if (lgr != '0) begin
            bus.bus_addr_oe = 1'b1;
            bus.bus_addr = trap_of(lvl_pick(lgr), trap_addr0_i, trap_addr1_i, trap_addr2_i, trap_addr3_i);
        end else if (ch_gnt) begin
            // driven for as long as the grant stands, which the host holds one cycle
            bus.bus_addr_oe = 1'b1;
            bus.bus_addr = chan_addr(st_reg.kind, word_count_addr_i, mem_addr_i);
        end
    end

    // ---------------------------------------------------------------
    // user outputs
    // ---------------------------------------------------------------
    // every user output is a field of the state register
    assign level_pending_o = st_reg.lreq;
    assign level_served_o = st_reg.lserved;
    assign channel_busy_o = st_reg.busy;
    assign channel_served_o = st_reg.cserved;
    assign add_error_o = st_reg.add_err;
endmodule
`default_nettype wire

// [iobpr_host.sv]
// host i/o processor end: sync pulse, enables, grants, overflow
`timescale 1ns/1ps
`default_nettype none
`include "iobpr_params.svh"
module iobpr_host (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // bus
    iobpr_bus_if.host bus,
    // user side
    input wire logic sync_period_tick_i,
    input wire logic add_third_cycle_i,
    input wire logic add_sign_a_i,
    input wire logic add_sign_b_i,
    input wire logic add_sign_sum_i,
    output logic level_break_o,
    output logic [1:0] level_served_o,
    output logic channel_break_o,
    output iobpr_pkg::iobpr_xfer_t xfer_kind_o,
    output logic [`IOBPR_ADDR_W-1:0] addr_o
);
    typedef struct packed {
        logic sync;
        logic [`IOBPR_LEVELS-1:0] lgrant;
        logic cgrant;
        logic oflo;
        logic lbreak;
        logic [1:0] lserved;
        logic cbreak;
        iobpr_pkg::iobpr_xfer_t kind;
        logic [`IOBPR_ADDR_W-1:0] addr;
    } iobpr_host_state_t;
    iobpr_host_state_t st_reg;
    iobpr_host_state_t st_next;

    // ---------------------------------------------------------------
    // grant decision
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.sync = sync_period_tick_i;
        st_next.lbreak = 1'b0;
        st_next.cbreak = 1'b0;
        st_next.lgrant = '0;
        st_next.cgrant = 1'b0;
        // overflow: like signs giving opposite-signed sum
        st_next.oflo = add_third_cycle_i && (add_sign_a_i == add_sign_b_i) && (add_sign_sum_i != add_sign_a_i);
        if (st_reg.lgrant != '0 || st_reg.cgrant) begin
            st_next.addr = bus.bus_addr; // capture address driven during grant
        end else if (!bus.channel_request_n || !bus.one_cycle_request_n) begin
            st_next.cgrant = 1'b1;
            st_next.cbreak = 1'b1;
            if (bus.channel_request_n) begin
                st_next.kind = iobpr_pkg::IOBPR_XFER_ONE_OUT;
            end else if (!bus.one_cycle_request_n) begin
                st_next.kind = iobpr_pkg::IOBPR_XFER_ONE_IN;
            end else begin
                st_next.kind = iobpr_pkg::IOBPR_XFER_MULTI;
            end
        end else begin
            // lowest index wins: level 0 highest
            for (int i = `IOBPR_LEVELS - 1; i >= 0; i--) begin
                if (!bus.level_request_n[i]) begin
                    st_next.lgrant = 4'h0;
                    st_next.lgrant[i] = 1'b1;
                    st_next.lserved = i[1:0];
                    st_next.lbreak = 1'b1;
                end
            end
        end
        if (srst_i) begin
            st_next = '0;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        st_reg <= st_next;
    end

    // bus and user outputs
    assign bus.io_sync = st_reg.sync;
    assign bus.level_grant = st_reg.lgrant;
    assign bus.channel_grant = st_reg.cgrant;
    assign bus.add_overflow = st_reg.oflo;
    assign bus.level_chain_enable = {`IOBPR_LEVELS{1'b1}};
    assign bus.channel_enable_in = 1'b1; // steady enable level
    assign level_break_o = st_reg.lbreak;
    assign level_served_o = st_reg.lserved;
    assign channel_break_o = st_reg.cbreak;
    assign xfer_kind_o = st_reg.kind;
    assign addr_o = st_reg.addr;
endmodule
`default_nettype wire

// [iobpr_monitor.sv]
// bus checker between the peripheral and host ends
`timescale 1ns/1ps
`default_nettype none
`include "iobpr_params.svh"
module iobpr_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // level lines
    input wire logic io_sync,
    input wire logic [`IOBPR_LEVELS-1:0] level_request_n,
    input wire logic [`IOBPR_LEVELS-1:0] level_grant,
    input wire logic [`IOBPR_LEVELS-1:0] level_chain_enable,
    input wire logic [`IOBPR_LEVELS-1:0] level_enable_out,
    // channel lines
    input wire logic channel_enable_in,
    input wire logic channel_enable_out,
    input wire logic channel_request_n,
    input wire logic one_cycle_request_n,
    input wire logic channel_grant,
    input wire logic bus_addr_oe
);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_ch_grant; channel_grant && !$past(channel_grant); endsequence
    sequence s_ch_addr; bus_addr_oe && channel_grant; endsequence
    property p_lvl_sync; (|(~level_request_n & $past(level_request_n))) |-> $past(io_sync); endproperty
    property p_lvl_en; !(|(~level_request_n & $past(level_request_n) & ~$past(level_chain_enable))); endproperty
    property p_lvl_cut; level_enable_out == (level_chain_enable & level_request_n); endproperty
    property p_lvl_hold; !(|($past(~level_request_n & ~level_grant & level_chain_enable) & level_request_n)); endproperty
    property p_lvl_rel; !(|($past(level_grant & ~level_request_n) & ~level_request_n)); endproperty
    property p_lvl_addr; (|(level_grant & ~level_request_n)) |-> bus_addr_oe; endproperty
    property p_ch_en; ($fell(channel_request_n) || $fell(one_cycle_request_n)) |-> $past(channel_enable_in); endproperty
    property p_ch_cut; !(channel_request_n && one_cycle_request_n) |-> !channel_enable_out; endproperty
    property p_ch_addr; s_ch_grant |-> s_ch_addr; endproperty
    property p_ch_rel; s_ch_grant |=> ##1 (channel_request_n && one_cycle_request_n); endproperty
    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    a_lvl_sync: assert property (p_lvl_sync) else $error("level request off sync");
    a_lvl_en: assert property (p_lvl_en) else $error("level request without enable");
    a_lvl_cut: assert property (p_lvl_cut) else $error("level chain out wrong");
    a_lvl_hold: assert property (p_lvl_hold) else $error("level request dropped");
    a_lvl_rel: assert property (p_lvl_rel) else $error("level request kept");
    a_lvl_addr: assert property (p_lvl_addr) else $error("no trap address");
    a_ch_en: assert property (p_ch_en) else $error("channel request without enable");
    a_ch_cut: assert property (p_ch_cut) else $error("channel chain not cut");
    a_ch_addr: assert property (p_ch_addr) else $error("no channel address");
    a_ch_rel: assert property (p_ch_rel) else $error("channel request kept");
endmodule
`default_nettype wire

// [iobpr_params.svh]
// constants for the i/o bus priority request logic
`ifndef IOBPR_PARAMS_SVH
`define IOBPR_PARAMS_SVH
`define IOBPR_LEVELS 4
`define IOBPR_ADDR_W 15
`define IOBPR_ADDR_RESET 15'h0000
`define IOBPR_ADD_CYCLES 2'h3
`endif

// [iobpr_pkg.sv]
// types shared by both ends of the i/o bus priority request logic
`default_nettype none
package iobpr_pkg;
    typedef enum logic [1:0] {
        IOBPR_XFER_MULTI,
        IOBPR_XFER_ONE_IN,
        IOBPR_XFER_ONE_OUT
    } iobpr_xfer_t;
    typedef enum logic [1:0] {
        IOBPR_CH_IDLE,
        IOBPR_CH_WAIT,
        IOBPR_CH_GRANTED
    } iobpr_ch_state_t;
endpackage
`default_nettype wire

// [test_io_bus_priority_request_logic.sv]
// self-checking bench joining the host and peripheral ends
`timescale 1ns/1ps
`default_nettype none
`include "iobpr_params.svh"
module test_io_bus_priority_request_logic;
    // stimulus and observed signals
    logic clk = 1'b0, srst = 1'b1, tick = 1'b0, third = 1'b0, sa = 1'b0, sb = 1'b0, ss = 1'b0, ch_want = 1'b0;
    logic [3:0] want = 4'h0;
    logic [14:0] trap [4] = '{15'h0000, 15'h0000, 15'h0000, 15'h0000};
    logic [14:0] wc = 15'h0000, ma = 15'h0000, h_addr;
    iobpr_pkg::iobpr_xfer_t ch_kind = iobpr_pkg::IOBPR_XFER_MULTI, h_kind;
    logic h_lbrk, h_cbrk, d_busy, d_csrv, d_err;
    logic [1:0] h_lvl;
    logic [3:0] d_pend, d_lsrv;
    int error_cnt = 0, total_checks = 0, seed = 32'hD965, r;
    bit err_model;
    iobpr_bus_if bus_if();
    // both ends and the checker
    iobpr_host iobpr_host_i (.clk_i(clk), .srst_i(srst), .bus(bus_if), .sync_period_tick_i(tick),
        .add_third_cycle_i(third), .add_sign_a_i(sa), .add_sign_b_i(sb), .add_sign_sum_i(ss),
        .level_break_o(h_lbrk), .level_served_o(h_lvl), .channel_break_o(h_cbrk), .xfer_kind_o(h_kind), .addr_o(h_addr));
    iobpr_device iobpr_device_i (.clk_i(clk), .srst_i(srst), .bus(bus_if), .level_want_i(want),
        .trap_addr0_i(trap[0]), .trap_addr1_i(trap[1]), .trap_addr2_i(trap[2]), .trap_addr3_i(trap[3]),
        .level_pending_o(d_pend), .level_served_o(d_lsrv), .channel_want_i(ch_want), .channel_kind_i(ch_kind),
        .word_count_addr_i(wc), .mem_addr_i(ma), .channel_busy_o(d_busy), .channel_served_o(d_csrv), .add_error_o(d_err));
    iobpr_monitor iobpr_monitor_i (.clk_i(clk), .srst_i(srst), .io_sync(bus_if.io_sync),
        .level_request_n(bus_if.level_request_n), .level_grant(bus_if.level_grant),
        .level_chain_enable(bus_if.level_chain_enable), .level_enable_out(bus_if.level_enable_out),
        .channel_enable_in(bus_if.channel_enable_in), .channel_enable_out(bus_if.channel_enable_out),
        .channel_request_n(bus_if.channel_request_n), .one_cycle_request_n(bus_if.one_cycle_request_n),
        .channel_grant(bus_if.channel_grant), .bus_addr_oe(bus_if.bus_addr_oe));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    // compare, wait and verdict helpers
    task automatic chk(input string name, input logic [14:0] exp, input logic [14:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_hi(ref logic s, input string name);
        int n;
        n = 0;
        #1;
        while (s !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(name, 15'h0001, {14'h0, s});
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // level requests on a mask, served lowest index first
    task automatic level_run(input logic [3:0] mask, input bit sync);
        int q[$];
        @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            trap[i] <= r[14:0];
            if (mask[i] && sync) q.push_back(i);
        end
        want <= mask;
        tick <= sync;
        @(posedge clk);
        tick <= 1'b0;
        @(posedge clk);
        #1;
        chk("pending", {11'h0, mask & {4{sync}}}, {11'h0, d_pend});
        @(posedge clk);
        want <= 4'h0;
        while (q.size() > 0) begin
            wait_hi(h_lbrk, "level break");
            @(posedge clk);
            #1;
            chk("level", q[0][14:0], {13'h0, h_lvl});
            chk("trap addr", trap[q[0]], h_addr);
            void'(q.pop_front());
        end
    endtask
    // one channel transfer of a given kind
    task automatic chan_run(input iobpr_pkg::iobpr_xfer_t kind);
        @(posedge clk);
        r = $random(seed);
        wc <= r[14:0];
        ma <= r[29:15];
        ch_kind <= kind;
        ch_want <= 1'b1;
        wait_hi(d_busy, "channel busy");
        @(posedge clk);
        ch_want <= 1'b0;
        wait_hi(d_csrv, "channel served");
        chk("kind", {13'h0, kind}, {13'h0, h_kind});
        chk("channel addr", (kind == iobpr_pkg::IOBPR_XFER_MULTI) ? wc : ma, h_addr);
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        level_run(4'hF, 1'b0);
        level_run(4'hF, 1'b1);
        for (int j = 0; j < 6; j++) begin
            r = $random(seed);
            level_run(r[3:0], 1'b1);
        end
        for (int k = 0; k < 9; k++) begin
            @(posedge clk);
            third <= (k != 8);
            {sa, sb, ss} <= k[2:0];
            @(posedge clk);
            third <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            err_model = (k != 8) && (sa == sb) && (ss != sa);
            chk("add error", {14'h0, err_model}, {14'h0, d_err});
            chan_run(iobpr_pkg::iobpr_xfer_t'(k % 3));
            chk("add error clear", 15'h0000, {14'h0, d_err});
        end
        results();
    end
    // watchdog
    initial begin
        #200000;
        error_cnt++;
        $display("mismatch watchdog expected done seen hang");
        results();
    end
endmodule
`default_nettype wire
